// ==== pkg/ocr_pkg.sv ====
package ocr_pkg;
  // Stage and event layout
  localparam int OCR_NUM_STAGES = 4;
  localparam int OCR_HIST_DEPTH = 12;
  localparam int OCR_NUM_SIG = 9;
  localparam int OCR_SIG_START = 0;
  localparam int OCR_SIG_TRIP = 1;
  localparam int OCR_SIG_BLOCK = 2;
  localparam int OCR_SIG_PH_START = 3;
  localparam int OCR_SIG_PH_TRIP = 6;
  localparam int OCR_TS_W = 48;
  localparam int OCR_CUR_W = 16;
  localparam int OCR_TTR_W = 21;
  localparam int OCR_SG_W = 3;
  localparam int OCR_FT_W = 4;
  localparam int OCR_EVT_W = 5;
  localparam int OCR_STG_W = 2;
  localparam int OCR_IDX_W = 4;
  // Stored record: time, code, fault type, three currents, trip time, group
  localparam int OCR_REC_W = OCR_TS_W + OCR_EVT_W + OCR_FT_W + 3 * OCR_CUR_W
    + OCR_TTR_W + OCR_SG_W;
  // Remaining trip time in ms, upper limit
  localparam int OCR_TTR_MAX_S = 1800;
  localparam logic [20:0] OCR_TTR_MAX_MS = 21'(OCR_TTR_MAX_S * 1000);
  localparam logic [3:0] OCR_WR_PTR_RST = 4'h0;
  localparam logic [3:0] OCR_CNT_RST = 4'h0;

  typedef enum logic [1:0]
  {
    OCR_SEL_ON = 2'b00,
    OCR_SEL_OFF = 2'b01,
    OCR_SEL_BOTH = 2'b10
  } ocr_sel_t;
endpackage

// ==== src/ocr_hist.sv ====
`timescale 1ns/1ps
`default_nettype none
// Per-stage twelve entry fault record ring
module ocr_hist
  import ocr_pkg::*;
#(
  parameter int DEPTH = OCR_HIST_DEPTH,
  parameter int REC_W = 64
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Write side
  input wire logic wr_en,
  input wire logic [REC_W-1:0] wr_rec,
  // Read side, index 0 is newest
  input wire logic [OCR_IDX_W-1:0] rd_idx,
  output logic [REC_W-1:0] rd_rec,
  output logic [OCR_IDX_W-1:0] rec_cnt
);
  typedef struct packed
  {
    logic [OCR_IDX_W-1:0] wp;
    logic [OCR_IDX_W-1:0] cnt;
    logic [REC_W-1:0] rd;
  } ocr_hist_st_t;

  ocr_hist_st_t st_ff;
  ocr_hist_st_t nxt_st;
  logic [REC_W-1:0] mem [DEPTH];
  logic [OCR_IDX_W-1:0] rd_slot;

  always_comb
  begin
    // Newest entry sits just behind the write pointer
    if (rd_idx < st_ff.wp)
      rd_slot = OCR_IDX_W'(st_ff.wp - rd_idx - 1'b1);
    else
      rd_slot = OCR_IDX_W'(DEPTH + st_ff.wp - rd_idx - 1);
    nxt_st = st_ff;
    nxt_st.rd = (rd_idx < st_ff.cnt) ? mem[rd_slot] : '0;
    if (wr_en)
    begin
      // Full ring wraps and replaces the oldest
      nxt_st.wp = (st_ff.wp == OCR_IDX_W'(DEPTH - 1)) ? '0 : st_ff.wp + 1'b1;
      if (st_ff.cnt != OCR_IDX_W'(DEPTH))
        nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_ff.wp <= OCR_WR_PTR_RST;
      st_ff.cnt <= OCR_CNT_RST;
      st_ff.rd <= '0;
    end
    else if (clk_en)
      st_ff <= nxt_st;
  end

  // Storage left unreset on purpose; count gates reads
  always_ff @(posedge core_clk)
  begin
    if (clk_en && wr_en)
      mem[st_ff.wp] <= wr_rec;
  end

  assign rd_rec = st_ff.rd;
  assign rec_cnt = st_ff.cnt;
endmodule
`default_nettype wire

// ==== src/ocr_recorder.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Status change yields event; start, trip, blocked ON edges also record
// - User selects ON, OFF or both
// - Four stages, events tagged per stage
// - Events carry time stamp, process data
// - Keep twelve most recent fault records
// - Separate history for every stage
// - Records only on ON transitions
// - Record holds time, name, currents, group
module ocr_recorder
  import ocr_pkg::*;
#(
  parameter int NSTG = OCR_NUM_STAGES,
  parameter int DEPTH = OCR_HIST_DEPTH
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Stage status: start, trip, blocked, start A/B/C, trip A/B/C
  input wire logic [NSTG*OCR_NUM_SIG-1:0] stage_status,
  // Process data per stage; setting group shared by all stages
  input wire logic [NSTG*OCR_CUR_W-1:0] pre_trig_cur,
  input wire logic [NSTG*OCR_CUR_W-1:0] fault_cur,
  input wire logic [NSTG*OCR_CUR_W-1:0] pre_fault_cur,
  input wire logic [NSTG*OCR_TTR_W-1:0] trip_time_rem,
  input wire logic [NSTG*OCR_FT_W-1:0] fault_type,
  input wire logic [OCR_SG_W-1:0] setting_group,
  // Time and event selection
  input wire logic [OCR_TS_W-1:0] time_stamp,
  input wire logic [1:0] event_sel,
  // Event buffer sink
  output logic evt_valid,
  output logic [OCR_STG_W-1:0] evt_stage,
  output logic [OCR_EVT_W-1:0] evt_code,
  output logic evt_on,
  output logic [OCR_TS_W-1:0] evt_time,
  output logic [OCR_CUR_W-1:0] evt_fault_cur,
  output logic [OCR_FT_W-1:0] evt_fault_type,
  output logic evt_lost,
  // Fault history read
  input wire logic [OCR_STG_W-1:0] hist_stage,
  input wire logic [OCR_IDX_W-1:0] hist_idx,
  output logic [OCR_REC_W-1:0] hist_rec,
  output logic [OCR_IDX_W-1:0] hist_cnt
);
  localparam int REC_W = OCR_REC_W;
  localparam int NEV = NSTG * OCR_NUM_SIG;

  typedef struct packed
  {
    logic [NEV-1:0] prev;
    logic [NEV-1:0] pend_on;
    logic [NEV-1:0] pend_off;
    logic valid;
    logic [OCR_STG_W-1:0] stage;
    logic [OCR_EVT_W-1:0] code;
    logic on;
    logic [OCR_TS_W-1:0] tstamp;
    logic [OCR_CUR_W-1:0] fcur;
    logic [OCR_FT_W-1:0] ftype;
    logic lost;
    logic [REC_W-1:0] hrec;
    logic [OCR_IDX_W-1:0] hcnt;
  } ocr_st_t;

  ocr_st_t st_ff;
  ocr_st_t nxt_st;
  logic [NSTG-1:0] rec_wr;
  logic [REC_W-1:0] rec_data [NSTG];
  logic [REC_W-1:0] rd_rec [NSTG];
  logic [OCR_IDX_W-1:0] rd_cnt [NSTG];
  logic [NEV-1:0] rise;
  logic [NEV-1:0] fall;
  logic [NEV-1:0] want_on;
  logic [NEV-1:0] want_off;

  assign rise = stage_status & ~st_ff.prev;
  assign fall = ~stage_status & st_ff.prev;
  assign want_on = (event_sel != OCR_SEL_OFF) ? rise : '0;
  assign want_off = (event_sel == OCR_SEL_ON) ? '0 : fall;

  genvar g;
  generate
    for (g = 0; g < NSTG; g++)
    begin : g_stage
      logic [OCR_NUM_SIG-1:0] on_bits;
      logic [OCR_EVT_W-1:0] first_on;
      logic [OCR_TTR_W-1:0] ttr;
      assign on_bits = rise[g*OCR_NUM_SIG +: OCR_NUM_SIG];
      always_comb
      begin
        first_on = '0;
        for (int k = 2; k >= 0; k--)
          if (on_bits[k])
            first_on = OCR_EVT_W'(2 * k);
      end
      assign ttr = (trip_time_rem[g*OCR_TTR_W +: OCR_TTR_W] > OCR_TTR_MAX_MS)
        ? OCR_TTR_MAX_MS : trip_time_rem[g*OCR_TTR_W +: OCR_TTR_W];
      // Only start, trip, blocked ON edges record
      assign rec_wr[g] = clk_en && (|on_bits[OCR_SIG_BLOCK:OCR_SIG_START]);
      assign rec_data[g] = {time_stamp, first_on,
        fault_type[g*OCR_FT_W +: OCR_FT_W],
        pre_trig_cur[g*OCR_CUR_W +: OCR_CUR_W],
        fault_cur[g*OCR_CUR_W +: OCR_CUR_W],
        pre_fault_cur[g*OCR_CUR_W +: OCR_CUR_W],
        ttr, setting_group};
      ocr_hist #(
        .DEPTH(DEPTH),
        .REC_W(REC_W)
      ) u_hist (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .wr_en(rec_wr[g]),
        .wr_rec(rec_data[g]),
        .rd_idx(hist_idx),
        .rd_rec(rd_rec[g]),
        .rec_cnt(rd_cnt[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic [NEV-1:0] on_q;
    logic [NEV-1:0] off_q;
    logic found;
    int sidx;
    on_q = st_ff.pend_on | want_on;
    off_q = st_ff.pend_off | want_off;
    found = 1'b0;
    sidx = 0;
    nxt_st = st_ff;
    nxt_st.prev = stage_status;
    nxt_st.valid = 1'b0;
    // Repeated edge before drain is counted as lost
    nxt_st.lost = |((st_ff.pend_on & want_on) | (st_ff.pend_off & want_off));
    // One event per cycle; lowest index wins, rest wait
    for (int i = 0; i < NEV; i++)
    begin
      if (!found && (on_q[i] || off_q[i]))
      begin
        found = 1'b1;
        sidx = i / OCR_NUM_SIG;
        nxt_st.valid = 1'b1;
        nxt_st.stage = OCR_STG_W'(sidx);
        // Code: signal index times two, plus one for OFF
        nxt_st.on = on_q[i];
        nxt_st.code = OCR_EVT_W'(2 * (i % OCR_NUM_SIG) + (on_q[i] ? 0 : 1));
        if (on_q[i])
          on_q[i] = 1'b0;
        else
          off_q[i] = 1'b0;
        nxt_st.tstamp = time_stamp;
        nxt_st.fcur = fault_cur[sidx*OCR_CUR_W +: OCR_CUR_W];
        nxt_st.ftype = fault_type[sidx*OCR_FT_W +: OCR_FT_W];
      end
    end
    nxt_st.pend_on = on_q;
    nxt_st.pend_off = off_q;
    nxt_st.hrec = rd_rec[hist_stage];
    nxt_st.hcnt = rd_cnt[hist_stage];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      st_ff <= '0;
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign evt_valid = st_ff.valid;
  assign evt_stage = st_ff.stage;
  assign evt_code = st_ff.code;
  assign evt_on = st_ff.on;
  assign evt_time = st_ff.tstamp;
  assign evt_fault_cur = st_ff.fcur;
  assign evt_fault_type = st_ff.ftype;
  assign evt_lost = st_ff.lost;
  assign hist_rec = st_ff.hrec;
  assign hist_cnt = st_ff.hcnt;
endmodule
`default_nettype wire

// ==== testbench/ocr_recorder_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocr_recorder_assertions
  import ocr_pkg::*;
#(
  parameter int DEPTH = OCR_HIST_DEPTH
)
(
  // Block inputs
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [35:0] stage_status,
  input wire logic [47:0] time_stamp,
  input wire logic [1:0] event_sel,
  input wire logic [1:0] hist_stage,
  // Block outputs
  input wire logic evt_valid,
  input wire logic [1:0] evt_stage,
  input wire logic [4:0] evt_code,
  input wire logic evt_on,
  input wire logic [47:0] evt_time,
  input wire logic [3:0] hist_cnt
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Lowest bit wins, so this event never queues
  sequence s_rise;
    clk_en && $rose(stage_status[0]);
  endsequence
  sequence s_rec;
    s_rise ##0 hist_stage == 2'h0 && hist_cnt < DEPTH ##1 clk_en && $stable(hist_stage);
  endsequence
  a_reset_clear: assert property ($fell(sys_rst) |-> !evt_valid && hist_cnt == 4'h0)
    else $error("not clear after reset");
  a_start_evt: assert property (s_rise ##0 event_sel != OCR_SEL_OFF
    |=> evt_valid && evt_on && evt_code == 5'h00
    && evt_stage == 2'h0 && evt_time == $past(time_stamp))
    else $error("bad start event");
  a_rec_count: assert property (s_rec |=> hist_cnt == $past(hist_cnt, 2) + 4'h1)
    else $error("record not counted");
  a_cnt_limit: assert property (hist_cnt <= DEPTH)
    else $error("history too deep");
  a_sel_filter: assert property (evt_valid && $stable(event_sel) && event_sel < 2'h2
    |-> evt_on == (event_sel == OCR_SEL_ON))
    else $error("filtered event sent");
  a_code_dir: assert property (evt_valid |-> evt_on == !evt_code[0])
    else $error("code and direction differ");
  a_code_range: assert property (evt_valid |-> evt_code < 5'h12)
    else $error("code out of range");
  a_freeze_hold: assert property (!clk_en |=> $stable({evt_valid, evt_code, evt_time}))
    else $error("moved while frozen");
endmodule
bind ocr_recorder ocr_recorder_assertions #(.DEPTH(DEPTH)) u_ocr_recorder_assertions (
  .core_clk, .sys_rst, .clk_en, .stage_status, .time_stamp, .event_sel, .hist_stage,
  .evt_valid, .evt_stage, .evt_code, .evt_on, .evt_time, .hist_cnt);
`default_nettype wire

// ==== testbench/test_ocr_recorder.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_ocr_recorder
  import ocr_pkg::*;
();
  logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, evt_valid, evt_on, evt_lost;
  logic [35:0] stage_status = '0;
  logic [63:0] pre_trig_cur = 64'h1004_1003_1002_1001, fault_cur = 64'h2004_2003_2002_2001;
  logic [63:0] pre_fault_cur = 64'h3004_3003_3002_3001;
  // Stage 2 asks for more than the clamp allows
  logic [83:0] trip_time_rem = 84'h0_0000_7FFF_FC00_0000_0000;
  logic [15:0] fault_type = 16'h4321, evt_fault_cur;
  logic [2:0] setting_group = 3'h5;
  logic [47:0] time_stamp = 48'h0000_0000_0100, evt_time, t_old;
  logic [1:0] event_sel = 2'h2, hist_stage = 2'h0, evt_stage;
  logic [3:0] hist_idx = 4'h0, hist_cnt, evt_fault_type;
  logic [4:0] evt_code;
  logic [128:0] hist_rec;
  int n_fail = 0, total_checks = 0;
  ocr_recorder u_ocr_recorder (.core_clk, .sys_rst, .clk_en, .stage_status, .pre_trig_cur,
    .fault_cur, .pre_fault_cur, .trip_time_rem, .fault_type, .setting_group, .time_stamp,
    .event_sel, .evt_valid, .evt_stage, .evt_code, .evt_on, .evt_time, .evt_fault_cur,
    .evt_fault_type, .evt_lost, .hist_stage, .hist_idx, .hist_rec, .hist_cnt);
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [128:0] seen, input logic [128:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %0t: %0h not %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic drive(input int b, input logic v);
    tick(1);
    stage_status[b] = v;
    time_stamp = time_stamp + 48'h0001;
    tick(1);
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    tick(8);
    sys_rst = 1'b0;
    tick(1);
  endtask
  task automatic t_each;
    for (int b = 0; b < 36; b++)
    begin
      for (int v = 1; v >= 0; v--)
      begin
        drive(b, v[0]);
        chk({evt_valid, evt_stage, evt_code, evt_on},
          {1'b1, 2'(b/9), 5'(2*(b%9)+1-v), v[0]});
        chk({evt_time, evt_fault_cur, evt_fault_type},
          {time_stamp, fault_cur[b/9*16+:16], fault_type[b/9*4+:4]});
      end
    end
  endtask
  task automatic t_sel;
    for (int k = 0; k < 4; k++)
    begin
      event_sel = 2'(k);
      drive(9, 1'b1);
      chk(evt_valid, k != 1);
      drive(9, 1'b0);
      chk(evt_valid, k != 0);
    end
  endtask
  task automatic t_hist;
    do_reset;
    hist_stage = 2'h2;
    drive(18, 1'b1);
    drive(18, 1'b0);
    drive(21, 1'b1);
    drive(21, 1'b0);
    chk(hist_cnt, 1);
    hist_stage = 2'h3;
    tick(1);
    chk(hist_cnt, 0);
    hist_stage = 2'h2;
    clk_en = 1'b0;
    tick(2);
    clk_en = 1'b1;
    for (int n = 1; n < 13; n++)
    begin
      drive(18, 1'b1);
      if (n == 1)
        t_old = time_stamp;
      drive(18, 1'b0);
    end
    tick(2);
    chk(hist_cnt, 12);
    chk(hist_rec, {time_stamp - 48'h0001, 9'h003, 48'h1003_2003_3003,
      OCR_TTR_MAX_MS, 3'h5});
    hist_idx = 4'hb;
    tick(2);
    chk(hist_rec[128:81], t_old);
  endtask
  // Nine edges at once drain one per cycle; bit 8 re-rises while queued
  task automatic t_lost;
    stage_status[8:0] = 9'h1ff;
    tick(1);
    chk({evt_valid, evt_code, evt_lost}, {1'b1, 5'h00, 1'b0});
    stage_status[8] = 1'b0;
    tick(1);
    stage_status[8] = 1'b1;
    tick(1);
    chk({evt_valid, evt_code, evt_lost}, {1'b1, 5'h04, 1'b1});
    tick(6);
    chk({evt_valid, evt_code, evt_on}, {1'b1, 5'h10, 1'b1});
    tick(1);
    chk({evt_valid, evt_code, evt_on, evt_lost}, {1'b1, 5'h11, 1'b0, 1'b0});
    stage_status[8:0] = 9'h000;
    tick(10);
    chk(evt_valid, 1'b0);
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    do_reset;
    t_each;
    t_sel;
    t_hist;
    t_lost;
    wrap_up;
  end
  // Whole run needs about 260 cycles
  initial
  begin
    #10us;
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
